/* logic/ebhp_phase_if.sv */
// Purpose: Carries the bus phase from the sequencer to the pin driver.
// Assumes: Single clock domain; all fields but style come from sequencer flip-flops.
// Notes:   Purely combinational consumer on the pin side.
`timescale 1ns/10ps
interface ebhp_phase_if;
   import ebhp_pkg::*;
   ebhp_state_t  phase;
   logic [23:0]  addr;
   logic [15:0]  wdata;
   logic         write;
   logic [1:0]   lanes;
   logic         style;

   modport ctl (output phase, addr, wdata, write, lanes, style);
   modport pin (input  phase, addr, wdata, write, lanes, style);
endinterface

/* logic/ebhp_pins.sv */
// Purpose: Turns the bus phase into address/data and strobe pin levels.
// Assumes: Phase fields except style are registered in the sequencer.
// Notes:   Output enables are high while the pin is driven.
`timescale 1ns/10ps
module ebhp_pins (
   // Phase from sequencer
   ebhp_phase_if.pin        bus,
   // Address/data lanes
   output logic [15:0]      o_ad,
   output logic             o_ad_oe,
   output logic [7:0]       o_addr_hi,
   // Strobes
   output logic             o_ctrl_oe,
   output logic             o_address_latch_strobe,
   output logic             o_data_strobe_n,
   output logic             o_rw,
   output logic             o_lower_byte_enable_n,
   output logic             o_upper_byte_enable_n,
   output logic             o_rd_n,
   output logic             o_write_low_strobe_n,
   output logic             o_write_high_strobe_n
);
   import ebhp_pkg::*;

   logic in_cyc;
   logic active;

   assign in_cyc = (bus.phase == ST_T1) || active;
   assign active = (bus.phase == ST_T2) || (bus.phase == ST_T3);

   always_comb begin
      o_addr_hi              = bus.addr[23:16];
      // Released while the other master owns the bus.
      o_ctrl_oe              = (bus.phase != ST_HOLD);
      o_ad_oe                = o_ctrl_oe &&
                               ((bus.phase == ST_T1) ||
                                (active && bus.write));
      o_ad                   = (bus.phase == ST_T1) ? bus.addr[15:0]
                                                    : bus.wdata;
      o_address_latch_strobe = (bus.phase == ST_T1);
      o_upper_byte_enable_n  = !(in_cyc && bus.lanes[1]);
      o_data_strobe_n        = 1'b1;
      // Direction rests high outside writes, also just before hold.
      o_rw                   = 1'b1;
      o_lower_byte_enable_n  = 1'b1;
      o_rd_n                 = 1'b1;
      o_write_low_strobe_n   = 1'b1;
      o_write_high_strobe_n  = 1'b1;
      if (!bus.style) begin
         o_data_strobe_n       = !active;
         o_rw                  = !(in_cyc && bus.write);
         o_lower_byte_enable_n = !(in_cyc && bus.lanes[0]);
      end else begin
         o_rd_n                = !(active && !bus.write);
         o_write_low_strobe_n  = !(active && bus.write && bus.lanes[0]);
         o_write_high_strobe_n = !(active && bus.write && bus.lanes[1]);
      end
   end
endmodule // ebhp_pins

/* logic/ebhp_pkg.sv */
// Purpose: Shared constants and types of the external bus hold/priority unit.
// Assumes: 24-bit address space split in 16 blocks of 1 Mbyte.
// Notes:   Region bases are overridable defaults.
package ebhp_pkg;

   // ****************************************************************
   // Address map
   // ****************************************************************
   localparam int          ADDR_W       = 24;
   localparam int          BLK_MSB      = 23;
   localparam int          BLK_LSB      = 20;
   localparam logic [3:0]  ROM_BLOCK    = 4'h0;
   localparam logic [3:0]  TOP_BLOCK    = 4'hF;
   localparam logic [23:0] RAM_BASE_DEF = 24'hFFC000;
   localparam logic [23:0] PER_BASE_DEF = 24'hFFF000;
   localparam logic [23:0] HALF_STEP    = 24'h000002;

   // ****************************************************************
   // Idle-cycle control field layout
   // ****************************************************************
   localparam int          IDLE_CTL_W   = 16;
   localparam logic [15:0] IDLE_ODD_MSK = 16'hAAAA;

   // ****************************************************************
   // Access sizes, requesters and fetch filler
   // ****************************************************************
   localparam logic [1:0]  SZ_BYTE      = 2'h0;
   localparam logic [1:0]  SZ_HALF      = 2'h1;
   localparam logic [1:0]  SZ_WORD      = 2'h2;
   localparam logic [1:0]  SRC_DAT      = 2'h0;
   localparam logic [1:0]  SRC_BRF      = 2'h1;
   localparam logic [1:0]  SRC_SQF      = 2'h2;
   localparam logic [15:0] NOP_DEF      = 16'h0000;

   // ****************************************************************
   // Bus phase of the controller
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_T1,
      ST_T2,
      ST_T3,
      ST_TI,
      ST_HOLD
   } ebhp_state_t;

endpackage

/* logic/ebhp_region.sv */
// Purpose: Classifies an address and looks up its idle-state setting.
// Assumes: Internal RAM and peripheral area both lie in the top block.
// Notes:   Pure decode; no state.
`timescale 1ns/10ps
module ebhp_region #(
   parameter logic [23:0] RAM_BASE = ebhp_pkg::RAM_BASE_DEF,
   parameter logic [23:0] PER_BASE = ebhp_pkg::PER_BASE_DEF
) (
   // Address and idle control
   input  wire logic [23:0] i_addr,
   input  wire logic [15:0] i_idle_ctl,
   // Classification
   output logic             o_internal,
   output logic             o_periph,
   output logic             o_idle_en
);
   import ebhp_pkg::*;

   logic [3:0]  blk;
   logic [15:0] ctl_odd;
   logic        in_ram;

   assign blk     = i_addr[BLK_MSB:BLK_LSB];
   // Even bits are ignored.
   assign ctl_odd = i_idle_ctl & IDLE_ODD_MSK;
   assign in_ram  = (i_addr >= RAM_BASE) && (i_addr < PER_BASE);
   assign o_periph   = (i_addr >= PER_BASE);
   assign o_internal = (blk == ROM_BLOCK) || in_ram || o_periph;

   always_comb begin
      o_idle_en = ctl_odd[{blk[3:1], 1'b1}];
      if (blk == ROM_BLOCK) begin
         o_idle_en = 1'b0;
      end
      if (in_ram || o_periph) begin
         o_idle_en = 1'b0;
      end
   end
endmodule // ebhp_region

/* logic/ebhp_top.sv */
// Purpose: External bus sequencer with bus hold and cycle priority.
// Assumes: Requesters hold a request until its done pulse, then drop it.
// Notes:   Internal regions are answered at once with no external cycle.
//
// What this block does
// - No idle state ever for ROM block zero.
// - No idle state for internal RAM, peripherals.
// - Hold pins work only when enabled.
// - Low hold request floats bus and strobes.
// - High request ends hold, pins driven again.
// - During hold, stall only at external access.
// - Hold acknowledge low for whole hold period.
// - No hold between read-modify-write halves.
// - Clock stop mode never enters hold.
// - Halt mode grants hold at once, returns.
// - Two strobe styles chosen by configuration bit.
// - Unused byte lane carries don't-care data.
// - Request high at sample point means no hold.
// - Direction line may pulse high before hold.
// - Priority: hold, data, branch, sequential fetch.
// - Fetch may slip between read-modify-write halves.
// - Word halves back to back; only an idle state may sit between.
// - Peripheral-area fetch returns no-operation code.
// - No prefetch into peripheral area from RAM.
// - Data halfword and word addresses forced aligned.
// - Data access never crosses block boundary.
// - Word: low halfword first, high second.
`timescale 1ns/10ps
module ebhp_top #(
   parameter logic [23:0] RAM_BASE = ebhp_pkg::RAM_BASE_DEF,
   parameter logic [23:0] PER_BASE = ebhp_pkg::PER_BASE_DEF,
   parameter logic [15:0] NOP_CODE = ebhp_pkg::NOP_DEF
) (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   // Configuration
   input  wire logic        i_hold_pins_enable,
   input  wire logic        i_strobe_style_select,
   input  wire logic [15:0] i_idle_cycle_ctrl_reg,
   // Power state
   input  wire logic        i_halt_mode,
   input  wire logic        i_clock_stop_mode,
   // Operand data requests
   input  wire logic        i_dat_req,
   input  wire logic [23:0] i_dat_addr,
   input  wire logic [1:0]  i_dat_size,
   input  wire logic        i_dat_write,
   input  wire logic        i_dat_rmw,
   input  wire logic [31:0] i_dat_wdata,
   output logic             o_dat_done,
   output logic [31:0]      o_dat_rdata,
   // Instruction fetch requests
   input  wire logic        i_brf_req,
   input  wire logic [23:0] i_brf_addr,
   input  wire logic        i_sqf_req,
   input  wire logic [23:0] i_sqf_addr,
   output logic             o_brf_done,
   output logic             o_sqf_done,
   output logic [15:0]      o_fetch_data,
   output logic             o_ext_stall,
   // Address/data bus
   input  wire logic [15:0] i_ad,
   output logic [15:0]      o_ad,
   output logic             o_ad_oe,
   output logic [7:0]       o_addr_hi,
   // Strobes
   output logic             o_ctrl_oe,
   output logic             o_address_latch_strobe,
   output logic             o_data_strobe_n,
   output logic             o_rw,
   output logic             o_lower_byte_enable_n,
   output logic             o_upper_byte_enable_n,
   output logic             o_rd_n,
   output logic             o_write_low_strobe_n,
   output logic             o_write_high_strobe_n,
   // Bus hold
   input  wire logic        i_hold_request_n,
   output logic             o_hold_ack_n
);
   import ebhp_pkg::*;

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   generate
      if (RAM_BASE >= PER_BASE || RAM_BASE[BLK_MSB:BLK_LSB] != TOP_BLOCK)
      begin : g_bad_map
         $error("RAM and peripheral bases must sit ordered in top block");
      end
   endgenerate

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      ebhp_state_t  st;
      logic [23:0]  addr;
      logic [31:0]  wdata;
      logic         wr;
      logic [1:0]   lanes;
      logic [1:0]   size;
      logic [1:0]   src;
      logic         half2;
      logic         more;
      logic         idle_en;
      logic         rmw;
      logic         rmw_lock;
      logic [31:0]  rdata;
      logic [15:0]  fdata;
      logic         dat_done;
      logic         brf_done;
      logic         sqf_done;
   } ebhp_core_t;

   ebhp_core_t s_r;
   ebhp_core_t s_nxt;

   // Aligning makes a straddling access impossible.
   function automatic logic [23:0] ebhp_align(input logic [23:0] a,
                                              input logic [1:0]  sz);
      logic [23:0] r;
      r = a;
      if (sz == SZ_HALF) begin
         r = {a[23:1], 1'b0};
      end else if (sz == SZ_WORD) begin
         r = {a[23:2], 2'b00};
      end
      return r;
   endfunction

   // ****************************************************************
   // Arbitration
   // ****************************************************************
   logic        hold_req;
   logic        busy_done;
   logic [1:0]  sel_src;
   logic        sel_any;
   logic [23:0] sel_addr;
   logic        reg_internal;
   logic        reg_periph;
   logic        reg_idle;

   // The request pin is ignored unless the hold pins are enabled.
   assign hold_req  = i_hold_pins_enable && !i_hold_request_n;
   assign busy_done = s_r.dat_done || s_r.brf_done || s_r.sqf_done;
   assign sel_any   = i_dat_req || i_brf_req || i_sqf_req;

   always_comb begin
      sel_src  = SRC_SQF;
      sel_addr = i_sqf_addr;
      if (i_dat_req) begin
         sel_src  = SRC_DAT;
         sel_addr = ebhp_align(i_dat_addr, i_dat_size);
      end else if (i_brf_req) begin
         sel_src  = SRC_BRF;
         sel_addr = i_brf_addr;
      end
   end

   ebhp_region #(
      .RAM_BASE (RAM_BASE),
      .PER_BASE (PER_BASE)
   ) u_region (
      .i_addr     (sel_addr),
      .i_idle_ctl (i_idle_cycle_ctrl_reg),
      .o_internal (reg_internal),
      .o_periph   (reg_periph),
      .o_idle_en  (reg_idle)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      s_nxt          = s_r;
      s_nxt.dat_done = 1'b0;
      s_nxt.brf_done = 1'b0;
      s_nxt.sqf_done = 1'b0;
      case (s_r.st)
         ST_IDLE: begin
            // Hold is entered only here, between whole cycles.
            if (hold_req && !s_r.rmw_lock && !i_clock_stop_mode) begin
               s_nxt.st = ST_HOLD;
            end else if (sel_any && !busy_done) begin
               s_nxt.src     = sel_src;
               s_nxt.addr    = sel_addr;
               s_nxt.idle_en = reg_idle;
               s_nxt.half2   = 1'b0;
               s_nxt.more    = 1'b0;
               s_nxt.wr      = 1'b0;
               s_nxt.lanes   = 2'b11;
               s_nxt.size    = SZ_HALF;
               s_nxt.rmw     = 1'b0;
               if (sel_src == SRC_DAT) begin
                  s_nxt.wr    = i_dat_write;
                  s_nxt.size  = i_dat_size;
                  s_nxt.rmw   = i_dat_rmw;
                  s_nxt.wdata = i_dat_wdata;
                  if (i_dat_size == SZ_BYTE) begin
                     s_nxt.lanes = sel_addr[0] ? 2'b10 : 2'b01;
                     // The idle lane just repeats the byte.
                     s_nxt.wdata = {16'h0000, i_dat_wdata[7:0],
                                    i_dat_wdata[7:0]};
                  end
               end
               if (reg_internal) begin
                  // Answered on chip, with no idle state.
                  s_nxt.dat_done = (sel_src == SRC_DAT);
                  s_nxt.brf_done = (sel_src == SRC_BRF);
                  s_nxt.sqf_done = (sel_src == SRC_SQF);
                  if (reg_periph) begin
                     s_nxt.fdata = NOP_CODE;
                  end
                  if (sel_src == SRC_DAT) begin
                     s_nxt.rdata = 32'h0000_0000;
                  end
               end else begin
                  s_nxt.st = ST_T1;
               end
            end
         end
         ST_T1: begin
            s_nxt.st = ST_T2;
         end
         ST_T2: begin
            s_nxt.st = ST_T3;
         end
         ST_T3: begin
            if (s_r.src != SRC_DAT) begin
               s_nxt.fdata = i_ad;
            end else if (s_r.size == SZ_BYTE) begin
               s_nxt.rdata = {24'h000000,
                              s_r.addr[0] ? i_ad[15:8] : i_ad[7:0]};
            end else if (s_r.size == SZ_HALF) begin
               s_nxt.rdata = {16'h0000, i_ad};
            end else if (!s_r.half2) begin
               s_nxt.rdata[15:0] = i_ad;
            end else begin
               s_nxt.rdata[31:16] = i_ad;
            end
            if (s_r.src == SRC_DAT && s_r.size == SZ_WORD && !s_r.half2)
            begin
               // Second half goes straight on; hold and fetch wait.
               s_nxt.half2 = 1'b1;
               s_nxt.addr  = s_r.addr + HALF_STEP;
               s_nxt.more  = s_r.idle_en;
               s_nxt.st    = s_r.idle_en ? ST_TI : ST_T1;
            end else begin
               s_nxt.dat_done = (s_r.src == SRC_DAT);
               s_nxt.brf_done = (s_r.src == SRC_BRF);
               s_nxt.sqf_done = (s_r.src == SRC_SQF);
               if (s_r.src == SRC_DAT) begin
                  // A fetch may still run while the lock holds.
                  s_nxt.rmw_lock = s_r.rmw && !s_r.wr;
               end
               s_nxt.st = s_r.idle_en ? ST_TI : ST_IDLE;
            end
         end
         ST_TI: begin
            s_nxt.more = 1'b0;
            s_nxt.st   = s_r.more ? ST_T1 : ST_IDLE;
         end
         ST_HOLD: begin
            if (!hold_req) begin
               s_nxt.st = ST_IDLE;
            end else if (sel_any && !busy_done && reg_internal) begin
               // Internal work runs on; only external cycles wait.
               s_nxt.dat_done = (sel_src == SRC_DAT);
               s_nxt.brf_done = (sel_src == SRC_BRF);
               s_nxt.sqf_done = (sel_src == SRC_SQF);
               s_nxt.fdata    = reg_periph ? NOP_CODE : s_r.fdata;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   ebhp_phase_if bus ();

   assign bus.phase = s_r.st;
   assign bus.addr  = s_r.addr;
   assign bus.wdata = s_r.half2 ? s_r.wdata[31:16] : s_r.wdata[15:0];
   assign bus.write = s_r.wr;
   assign bus.lanes = s_r.lanes;
   assign bus.style = i_strobe_style_select;

   assign o_hold_ack_n = (s_r.st != ST_HOLD);
   assign o_dat_done   = s_r.dat_done;
   assign o_brf_done   = s_r.brf_done;
   assign o_sqf_done   = s_r.sqf_done;
   assign o_dat_rdata  = s_r.rdata;
   assign o_fetch_data = s_r.fdata;
   assign o_ext_stall  = (s_r.st == ST_HOLD) && sel_any && !reg_internal;

   ebhp_pins u_pins (
      .bus                    (bus),
      .o_ad                   (o_ad),
      .o_ad_oe                (o_ad_oe),
      .o_addr_hi              (o_addr_hi),
      .o_ctrl_oe              (o_ctrl_oe),
      .o_address_latch_strobe (o_address_latch_strobe),
      .o_data_strobe_n        (o_data_strobe_n),
      .o_rw                   (o_rw),
      .o_lower_byte_enable_n  (o_lower_byte_enable_n),
      .o_upper_byte_enable_n  (o_upper_byte_enable_n),
      .o_rd_n                 (o_rd_n),
      .o_write_low_strobe_n   (o_write_low_strobe_n),
      .o_write_high_strobe_n  (o_write_high_strobe_n)
   );

endmodule // ebhp_top

/* testbench/ebhp_ext_mem.sv */
// Purpose: External memory on the far side of the multiplexed bus.
// Assumes: Address taken with the latch strobe; 256 halfwords.
// Notes:   Undriven lanes show the inverse of their last level.
`timescale 1ns/10ps
module ebhp_ext_mem (
   // Bus pins
   input  wire logic        i_mclk,
   input  wire logic [15:0] i_ad,
   input  wire logic        i_ad_oe,
   input  wire logic        i_ctrl_oe,
   input  wire logic        i_ale,
   input  wire logic        i_rw,
   input  wire logic        i_ds_n,
   input  wire logic        i_lbe_n,
   input  wire logic        i_ube_n,
   input  wire logic        i_rd_n,
   input  wire logic        i_wrl_n,
   input  wire logic        i_wrh_n,
   // Read data
   output logic [15:0]      o_ad
);
   logic [15:0] mem [256];
   logic [7:0]  a_r;
   logic [15:0] last_r = 16'h0000;
   logic        rd, wr_lo, wr_hi;

   initial begin
      for (int i = 0; i < 256; i++) mem[i] = {8'hC3 ^ i[7:0], i[7:0]};
   end
   // Direction is trusted only under a strobe.
   assign rd    = i_ctrl_oe && (!i_rd_n || (!i_ds_n && i_rw));
   assign wr_lo = i_ctrl_oe && (!i_wrl_n || (!i_ds_n && !i_rw && !i_lbe_n));
   assign wr_hi = i_ctrl_oe && (!i_wrh_n || (!i_ds_n && !i_rw && !i_ube_n));
   assign o_ad  = (rd && !i_ad_oe) ? mem[a_r] : ~last_r;
   always @(posedge i_mclk) begin
      last_r <= o_ad;
      if (i_ale) a_r <= i_ad[8:1];
      if (wr_lo) mem[a_r][7:0] <= i_ad[7:0];
      if (wr_hi) mem[a_r][15:8] <= i_ad[15:8];
   end
endmodule // ebhp_ext_mem

/* testbench/ebhp_top_checker.sv */
// Purpose: Hold and strobe checks on the top ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound into every ebhp_top instance.
`timescale 1ns/10ps
module ebhp_top_checker (
   // Clock, reset and inputs
   input wire logic       i_mclk,
   input wire logic       i_rstn,
   input wire logic       i_hold_pins_enable,
   input wire logic       i_strobe_style_select,
   input wire logic       i_clock_stop_mode,
   input wire logic       i_hold_request_n,
   // Outputs
   input wire logic       o_hold_ack_n,
   input wire logic       o_ad_oe,
   input wire logic       o_ctrl_oe,
   input wire logic       o_address_latch_strobe,
   input wire logic       o_data_strobe_n,
   input wire logic       o_rd_n,
   input wire logic [7:0] o_addr_hi,
   input wire logic       o_ext_stall
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   a_hold_floats: assert property (
      !o_hold_ack_n |-> !o_ad_oe && !o_ctrl_oe) else $error("bus driven");
   a_pins_off: assert property (
      !i_hold_pins_enable && o_hold_ack_n |=> o_hold_ack_n)
      else $error("hold while pins off");
   a_stop_no_hold: assert property (
      i_clock_stop_mode && o_hold_ack_n |=> o_hold_ack_n)
      else $error("hold in stop mode");
   a_req_high: assert property (
      i_hold_request_n && o_hold_ack_n |=> o_hold_ack_n)
      else $error("hold without request");
   a_hold_stays: assert property (
      !o_hold_ack_n && !i_hold_request_n && i_hold_pins_enable
      |=> !o_hold_ack_n) else $error("ack dropped early");
   a_hold_ends: assert property (
      !o_hold_ack_n && i_hold_request_n |=> o_hold_ack_n && o_ctrl_oe)
      else $error("hold not ended");
   a_stall_hold: assert property (
      o_ext_stall |-> !o_hold_ack_n) else $error("stall outside hold");
   a_no_rom_bus: assert property (
      o_address_latch_strobe |-> o_addr_hi[7:4] != 4'h0)
      else $error("bus cycle to rom block");
   a_ds_style: assert property (
      o_address_latch_strobe && !i_strobe_style_select
      |=> !o_data_strobe_n [*2]) else $error("data strobe missing");
   a_rd_style: assert property (
      !i_strobe_style_select && o_ctrl_oe |-> o_rd_n)
      else $error("read strobe in style zero");
endmodule // ebhp_top_checker

bind ebhp_top ebhp_top_checker i_chk (.*);

/* testbench/ebhp_top_tb.sv */
// Purpose: Self-checking bench of ebhp_top.
// Assumes: External memory modelled by ebhp_ext_mem.
// Notes:   Every wait is bounded; a bound used up ends the run.
`timescale 1ns/10ps
module ebhp_top_tb;
   import ebhp_pkg::*;
   logic        i_mclk, i_rstn = 0, i_hold_pins_enable = 0;
   logic        i_strobe_style_select = 0, i_halt_mode = 0;
   logic        i_clock_stop_mode = 0, i_hold_request_n = 1;
   logic        i_dat_req = 0, i_dat_write = 0, i_dat_rmw = 0;
   logic        i_brf_req = 0, i_sqf_req = 0;
   logic [15:0] i_idle_cycle_ctrl_reg = 16'h0000;
   logic [23:0] i_dat_addr = 0, i_brf_addr = 0, i_sqf_addr = 0;
   logic [1:0]  i_dat_size = 2'h0;
   logic [31:0] i_dat_wdata = 0, o_dat_rdata;
   logic [15:0] i_ad, o_ad, o_fetch_data;
   logic [7:0]  o_addr_hi;
   logic        o_dat_done, o_brf_done, o_sqf_done, o_ext_stall, o_ad_oe;
   logic        o_ctrl_oe, o_address_latch_strobe, o_data_strobe_n, o_rw;
   logic        o_lower_byte_enable_n, o_upper_byte_enable_n, o_rd_n;
   logic        o_write_low_strobe_n, o_write_high_strobe_n, o_hold_ack_n;
   int          failures = 0;
   int          n_tests = 0;
   int          n;

   ebhp_top i_dut (.*);
   ebhp_ext_mem i_mem (
      .i_mclk, .i_ad(o_ad), .i_ad_oe(o_ad_oe), .i_ctrl_oe(o_ctrl_oe),
      .i_ale(o_address_latch_strobe), .i_rw(o_rw), .i_ds_n(o_data_strobe_n),
      .i_lbe_n(o_lower_byte_enable_n), .i_ube_n(o_upper_byte_enable_n),
      .i_rd_n(o_rd_n), .i_wrl_n(o_write_low_strobe_n),
      .i_wrh_n(o_write_high_strobe_n), .o_ad(i_ad)
   );

   initial begin
      i_mclk = 0;
      forever #4 i_mclk = ~i_mclk;
   end

   function automatic logic [15:0] pat(input logic [23:0] a);
      return {8'hC3 ^ a[8:1], a[8:1]};
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge i_mclk);
      #1;
   endtask
   task automatic wait_done();
      n = 0;
      do begin
         tick(1);
         n++;
      end while ({o_dat_done, o_brf_done, o_sqf_done} == 3'h0 && n < 40);
      if (n >= 40) begin
         failures++;
         wrap_up();
      end
   endtask
   task automatic run(input int s, input logic [23:0] a, input logic [1:0] z,
                      input logic w = 0, m = 0, input logic [31:0] d = 0);
      @(posedge i_mclk);
      i_dat_req <= (s == 0);
      i_brf_req <= (s == 1);
      i_sqf_req <= (s == 2);
      i_dat_addr <= a;
      i_brf_addr <= a;
      i_sqf_addr <= a;
      i_dat_size <= z;
      i_dat_write <= w;
      i_dat_rmw <= m;
      i_dat_wdata <= d;
      wait_done();
      @(posedge i_mclk);
      i_dat_req <= 0;
      i_brf_req <= 0;
      i_sqf_req <= 0;
   endtask

   task automatic t_reads();
      run(0, 24'h200010, SZ_HALF);
      chk("half cycles", 4, n);
      chk("half data", pat(24'h200010), o_dat_rdata[15:0]);
      run(0, 24'h200013, SZ_HALF);
      chk("aligned half", pat(24'h200012), o_dat_rdata[15:0]);
      run(0, 24'h200020, SZ_WORD);
      chk("word cycles", 7, n);
      chk("word", {pat(24'h200022), pat(24'h200020)}, o_dat_rdata);
   endtask
   task automatic t_idle();
      @(posedge i_mclk);
      i_idle_cycle_ctrl_reg <= 16'h0008;
      run(0, 24'h300010, SZ_WORD);
      chk("idle cycles", 8, n);
      @(posedge i_mclk);
      i_idle_cycle_ctrl_reg <= 16'h8002;
      run(0, 24'h000100, SZ_HALF);
      chk("rom cycles", 1, n);
      run(0, 24'hFFC010, SZ_HALF);
      chk("ram cycles", 1, n);
      run(0, 24'hFFF010, SZ_HALF);
      chk("periph cycles", 1, n);
      run(1, 24'hFFF100, SZ_HALF);
      chk("periph fetch", NOP_DEF, o_fetch_data);
   endtask
   task automatic t_writes();
      logic [15:0] p;
      @(posedge i_mclk);
      i_strobe_style_select <= 1;
      p = pat(24'h200030);
      run(0, 24'h200031, SZ_BYTE, 1, 0, 32'h77);
      run(0, 24'h200030, SZ_HALF);
      chk("odd byte", {8'h77, p[7:0]}, o_dat_rdata[15:0]);
      @(posedge i_mclk);
      i_strobe_style_select <= 0;
      p = pat(24'h200040);
      run(0, 24'h200040, SZ_BYTE, 1, 0, 32'h11);
      run(0, 24'h200040, SZ_HALF);
      chk("even byte", {p[15:8], 8'h11}, o_dat_rdata[15:0]);
   endtask
   task automatic t_prio();
      logic [2:0] e;
      @(posedge i_mclk);
      i_dat_req <= 1;
      i_dat_addr <= 24'h200010;
      i_dat_write <= 0;
      i_dat_rmw <= 0;
      i_brf_req <= 1;
      i_brf_addr <= 24'h200100;
      i_sqf_req <= 1;
      i_sqf_addr <= 24'h200200;
      e = 3'h4;
      repeat (3) begin
         wait_done();
         chk("done order", e, {o_dat_done, o_brf_done, o_sqf_done});
         @(posedge i_mclk);
         i_dat_req <= i_dat_req & ~e[2];
         i_brf_req <= i_brf_req & ~e[1];
         i_sqf_req <= i_sqf_req & ~e[0];
         e = e >> 1;
      end
   endtask
   task automatic t_gate();
      for (int k = 0; k < 3; k++) begin
         @(posedge i_mclk);
         i_hold_pins_enable <= (k != 0);
         i_clock_stop_mode <= (k == 1);
         i_halt_mode <= (k == 2);
         i_hold_request_n <= 0;
         tick(3);
         chk("gated ack", k != 2, o_hold_ack_n);
         @(posedge i_mclk);
         i_hold_request_n <= 1;
         tick(2);
         chk("ack released", 1, o_hold_ack_n);
      end
   endtask
   task automatic t_hold();
      @(posedge i_mclk);
      i_halt_mode <= 0;
      i_hold_request_n <= 0;
      tick(3);
      chk("ack in hold", 0, o_hold_ack_n);
      chk("oe in hold", 0, {o_ad_oe, o_ctrl_oe});
      run(0, 24'hFFC020, SZ_HALF);
      chk("internal in hold", 1, n);
      @(posedge i_mclk);
      i_dat_req <= 1;
      i_dat_addr <= 24'h200010;
      tick(3);
      chk("stalled external", 0, o_dat_done);
      chk("stall", 1, o_ext_stall);
      @(posedge i_mclk);
      i_hold_request_n <= 1;
      wait_done();
      chk("done after hold", 1, o_dat_done);
      @(posedge i_mclk);
      i_dat_req <= 0;
   endtask
   task automatic t_rmw();
      run(0, 24'h200050, SZ_HALF, 0, 1);
      @(posedge i_mclk);
      i_hold_request_n <= 0;
      run(2, 24'h200060, SZ_HALF);
      chk("fetch in lock", pat(24'h200060), o_fetch_data);
      chk("ack in lock", 1, o_hold_ack_n);
      run(0, 24'h200050, SZ_HALF, 1, 0, 32'h1234);
      tick(3);
      chk("ack after write", 0, o_hold_ack_n);
      @(posedge i_mclk);
      i_hold_request_n <= 1;
      tick(2);
   endtask

   initial begin
      repeat (8) @(posedge i_mclk);
      i_rstn <= 1;
      tick(1);
      chk("reset ack", 1, o_hold_ack_n);
      chk("reset oe", 2'h1, {o_ad_oe, o_ctrl_oe});
      t_reads();
      t_idle();
      t_writes();
      t_prio();
      t_gate();
      t_hold();
      t_rmw();
      wrap_up();
   end
endmodule // ebhp_top_tb
